//--- rtl/lpcg_top.sv
// The implementer's own choices: register access over Wishbone and the register addresses.
`timescale 1ns/1ps
`include "lpcg_defs.svh"

module lpcg_top #(
  parameter int NUM_IRQ    = `LPCG_NUM_IRQ,
  parameter int NUM_PERIPH = `LPCG_NUM_PERIPH
) (
  input  wire logic                      clk_i,
  input  wire logic                      rst_i,
  // Wishbone classic slave
  input  wire logic                      wb_cyc_i,
  input  wire logic                      wb_stb_i,
  input  wire lpcg_pkg::lpcg_wb_req_s    wb_req_i,
  output logic                           wb_ack_o,
  output logic [31:0]                    wb_dat_o,
  // Core side, same clock
  input  wire logic                      wait_for_interrupt_entry_i,
  input  wire logic                      wait_for_event_entry_i,
  input  wire logic                      deep_sleep_select_i,
  input  wire logic [NUM_IRQ-1:0]        irq_i,
  input  wire logic                      nmi_i,
  input  wire logic                      dma_done_i,
  output logic                           wakeup_event_o,
  // Clock gate enables
  output lpcg_pkg::lpcg_core_clk_s       core_clk_en_o,
  output lpcg_pkg::lpcg_periph_clk_s     periph_clk_en_o
);
  import lpcg_pkg::*;

  // The reset mask constant covers only the documented lines; the read mux pads to 32 bits
  if (NUM_IRQ < 1 || NUM_IRQ > `LPCG_NUM_IRQ) begin : g_bad_irq
    $error("lpcg_top: NUM_IRQ must be 1 to 26");
  end
  // The gate register maps bit for bit onto the peripheral enable struct
  if (NUM_PERIPH != $bits(lpcg_periph_clk_s)) begin : g_bad_periph
    $error("lpcg_top: NUM_PERIPH must equal the peripheral enable struct width");
  end

  lpcg_state_e            state_ff;
  lpcg_state_e            nxt_state;
  lpcg_core_clk_s         nxt_core_clk;
  logic                   ev_kind_ff;
  logic                   nxt_ev_kind;
  logic                   ev_pend_ff;
  logic                   ev_consume;
  logic [NUM_PERIPH-1:0]  gate_q;
  logic [NUM_IRQ-1:0]     irq_mask_q;
  logic                   wb_ack_ff;
  logic [31:0]            wb_dat_ff;

  // Bus decode; ack comes one cycle after the request and drops the cycle after
  wire        bus_req     = wb_cyc_i & wb_stb_i & ~wb_ack_ff;
  wire        bus_wr      = bus_req & wb_req_i.we;
  wire        hit_gate    = (wb_req_i.adr == `LPCG_OFS_GATE);
  wire        hit_irqmask = (wb_req_i.adr == `LPCG_OFS_IRQMASK);
  wire        hit_status  = (wb_req_i.adr == `LPCG_OFS_STATUS);
  wire        wr_gate     = bus_wr & hit_gate;
  wire        wr_irqmask  = bus_wr & hit_irqmask;

  // Live flags for software; the deep select bit is the core's level as it stands now
  logic [31:0] status_word;

  always_comb begin
    status_word                   = 32'h0000_0000;
    status_word[`LPCG_ST_LIGHT]   = (state_ff == LPCG_LIGHT);
    status_word[`LPCG_ST_DEEP]    = (state_ff == LPCG_DEEP);
    status_word[`LPCG_ST_WAKING]  = (state_ff == LPCG_WAKE);
    status_word[`LPCG_ST_EVKIND]  = ev_kind_ff;
    status_word[`LPCG_ST_EVPEND]  = ev_pend_ff;
    status_word[`LPCG_ST_DEEPSEL] = deep_sleep_select_i;
  end

  // Unmapped addresses read as zero and ignore writes
  wire [31:0] rd_mux = hit_gate    ? {17'h0_0000, gate_q} :
                       hit_irqmask ? {{(32-NUM_IRQ){1'b0}}, irq_mask_q} :
                       hit_status  ? status_word : 32'h0000_0000;

  // Peripheral gate enables, one bit per clock
  lpcg_reg_bank #(
    .WIDTH     (NUM_PERIPH),
    .RESET_VAL (`LPCG_GATE_RST)
  ) u_gate (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .wr_i    (wr_gate),
    .sel_i   (wb_req_i.sel),
    .wdata_i (wb_req_i.dat),
    .q_o     (gate_q)
  );

  // Per-line wake mask for the maskable request lines
  lpcg_reg_bank #(
    .WIDTH     (NUM_IRQ),
    .RESET_VAL (NUM_IRQ'(`LPCG_IRQMASK_RST))
  ) u_irqmask (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .wr_i    (wr_irqmask),
    .sel_i   (wb_req_i.sel),
    .wdata_i (wb_req_i.dat),
    .q_o     (irq_mask_q)
  );

  // The non-maskable line wakes from any interrupt wait, but not from an event wait; masked lines are ignored for wake only
  wire irq_wake   = (|(irq_i & irq_mask_q)) | nmi_i;
  wire wake_hit   = ev_kind_ff ? ev_pend_ff : irq_wake;
  wire sleeping   = (state_ff == LPCG_LIGHT) | (state_ff == LPCG_DEEP);
  // An event latched before the wait makes the wait fall straight through
  wire wfe_skip   = (state_ff == LPCG_RUN) & wait_for_event_entry_i & ev_pend_ff;
  // A wait for event with an event already latched is no entry at all
  wire sleep_entry = wait_for_interrupt_entry_i | (wait_for_event_entry_i & ~ev_pend_ff);

  assign ev_consume = wfe_skip | (sleeping & ev_kind_ff & ev_pend_ff);

  // Set wins: a completion in the cycle that consumes the old event stays latched
  wire nxt_ev_pend = dma_done_i | (ev_pend_ff & ~ev_consume);

  always_comb begin
    nxt_state    = state_ff;
    nxt_ev_kind  = ev_kind_ff;
    nxt_core_clk = core_clk_en_o;
    case (state_ff)
      // Run: every core clock on; a wait pulse picks light or deep sleep
      LPCG_RUN: begin
        nxt_core_clk = '{cpu: 1'b1, ahb: 1'b1, apb: 1'b1, mem: 1'b1};
        if (sleep_entry) begin
          nxt_ev_kind      = ~wait_for_interrupt_entry_i;
          nxt_core_clk.cpu = 1'b0;
          if (deep_sleep_select_i) begin
            nxt_state        = LPCG_DEEP;
            nxt_core_clk.ahb = 1'b0;
            nxt_core_clk.apb = 1'b0;
            nxt_core_clk.mem = 1'b0;
          end else begin
            nxt_state = LPCG_LIGHT;
          end
        end
      end
      // Asleep: the peripheral gates stay as software left them
      LPCG_LIGHT, LPCG_DEEP: begin
        if (wake_hit) begin
          nxt_state    = LPCG_WAKE;
          nxt_core_clk = '{cpu: 1'b0, ahb: 1'b1, apb: 1'b1, mem: 1'b1};
        end
      end
      // Buses had one cycle to settle; every wake pays it, even from light sleep
      LPCG_WAKE: begin
        nxt_state    = LPCG_RUN;
        nxt_core_clk = '{cpu: 1'b1, ahb: 1'b1, apb: 1'b1, mem: 1'b1};
      end
      // Unreachable: every 2-bit code is a state; no power-off state exists, fall back to run
      default: begin
        nxt_state    = LPCG_RUN;
        nxt_core_clk = '{cpu: 1'b1, ahb: 1'b1, apb: 1'b1, mem: 1'b1};
      end
    endcase
  end

  // Sleep sequencer and the registered clock enables
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_ff      <= LPCG_RUN;
      core_clk_en_o <= '{cpu: 1'b1, ahb: 1'b1, apb: 1'b1, mem: 1'b1};
      ev_kind_ff    <= 1'b0;
    end else begin
      state_ff      <= nxt_state;
      core_clk_en_o <= nxt_core_clk;
      ev_kind_ff    <= nxt_ev_kind;
    end
  end

  // Event latch: a completion in the consuming cycle is kept, set wins
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ev_pend_ff     <= 1'b0;
      wakeup_event_o <= 1'b0;
    end else begin
      ev_pend_ff     <= nxt_ev_pend;
      wakeup_event_o <= dma_done_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_ff <= 1'b0;
    end else begin
      wb_ack_ff <= bus_req;
    end
  end

  // Read data is zero outside the ack cycle, so several slaves can share one return bus
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_ff <= 32'h0000_0000;
    end else begin
      wb_dat_ff <= (bus_req && !wb_req_i.we) ? rd_mux : 32'h0000_0000;
    end
  end

  assign wb_ack_o        = wb_ack_ff;
  assign wb_dat_o        = wb_dat_ff;
  // Not forced off in sleep: a running peripheral may be the one that raises the wake
  assign periph_clk_en_o = lpcg_periph_clk_s'(gate_q);

endmodule

//--- rtl/lpcg_defs.svh
`ifndef LPCG_DEFS_SVH
`define LPCG_DEFS_SVH

// Register byte offsets on the register bus
`define LPCG_OFS_GATE     32'h0000_0000
`define LPCG_OFS_IRQMASK  32'h0000_0004
`define LPCG_OFS_STATUS   32'h0000_0008

// Field widths
`define LPCG_NUM_IRQ      26
`define LPCG_NUM_PULSE    8
`define LPCG_NUM_PERIPH   15

// Reset values: every peripheral clock runs, every request line may wake
`define LPCG_GATE_RST     15'h7fff
`define LPCG_IRQMASK_RST  26'h3ff_ffff

// Status register field positions
`define LPCG_ST_LIGHT     0
`define LPCG_ST_DEEP      1
`define LPCG_ST_WAKING    2
`define LPCG_ST_EVKIND    3
`define LPCG_ST_EVPEND    4
`define LPCG_ST_DEEPSEL   5

`endif

//--- rtl/lpcg_pkg.sv
`include "lpcg_defs.svh"

package lpcg_pkg;

  typedef enum logic [1:0] {
    LPCG_RUN,
    LPCG_LIGHT,
    LPCG_DEEP,
    LPCG_WAKE
  } lpcg_state_e;

  typedef struct packed {
    logic [31:0] adr;
    logic        we;
    logic [3:0]  sel;
    logic [31:0] dat;
  } lpcg_wb_req_s;

  typedef struct packed {
    logic cpu;
    logic ahb;
    logic apb;
    logic mem;
  } lpcg_core_clk_s;

  typedef struct packed {
    logic                       random_gen_clock;
    logic                       watchdog_clock;
    logic [`LPCG_NUM_PULSE-1:0] pulse_clocks;
    logic                       timer_clock_1;
    logic                       timer_clock_0;
    logic                       async_serial_clock;
    logic                       sync_serial_clock;
    logic                       converter_clock;
  } lpcg_periph_clk_s;

endpackage

//--- rtl/lpcg_reg_bank.sv
`timescale 1ns/1ps
// Byte-lane writable register of WIDTH bits, low-aligned in a 32-bit word
module lpcg_reg_bank #(
  parameter int               WIDTH     = 15,
  parameter logic [WIDTH-1:0] RESET_VAL = '1
) (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic             wr_i,
  input  wire logic [3:0]       sel_i,
  input  wire logic [31:0]      wdata_i,
  output logic      [WIDTH-1:0] q_o
);

  // Each register sits low-aligned in one bus word
  if (WIDTH < 1 || WIDTH > 32) begin : g_bad_width
    $error("lpcg_reg_bank: WIDTH must be 1 to 32");
  end

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      wire lane_wr = wr_i & sel_i[i/8];
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          q_o[i] <= RESET_VAL[i];
        end else if (lane_wr) begin
          q_o[i] <= wdata_i[i];
        end
      end
    end
  endgenerate

endmodule

//--- dv/lpcg_monitor.sv
`timescale 1ns/1ps
`include "lpcg_defs.svh"
module lpcg_monitor (
  input wire logic                         clk_i,
  input wire logic                         rst_i,
  input wire logic                         wb_cyc_i,
  input wire logic                         wb_stb_i,
  input wire lpcg_pkg::lpcg_wb_req_s       wb_req_i,
  input wire logic                         wb_ack_o,
  input wire logic [31:0]                  wb_dat_o,
  input wire logic                         wait_for_interrupt_entry_i,
  input wire logic                         wait_for_event_entry_i,
  input wire logic                         deep_sleep_select_i,
  input wire logic [`LPCG_NUM_IRQ-1:0]     irq_i,
  input wire logic                         nmi_i,
  input wire logic                         dma_done_i,
  input wire logic                         wakeup_event_o,
  input wire lpcg_pkg::lpcg_core_clk_s     core_clk_en_o,
  input wire lpcg_pkg::lpcg_periph_clk_s   periph_clk_en_o
);
  import lpcg_pkg::*;
  logic kind_ff;
  wire  run_w = core_clk_en_o == 4'hf;
  wire  wr_w  = wb_cyc_i && wb_stb_i && wb_req_i.we;
  // Entry kind decides which source may wake
  always_ff @(posedge clk_i) begin
    if (rst_i) kind_ff <= 1'b0;
    else if ((wait_for_interrupt_entry_i || wait_for_event_entry_i) && run_w)
      kind_ff <= !wait_for_interrupt_entry_i;
  end
  default clocking dc @(posedge clk_i); endclocking
  default disable iff (rst_i);
  AST_RST_RUN: assert property (@(posedge clk_i) disable iff (1'b0)
    $fell(rst_i) |-> run_w && periph_clk_en_o == 15'h7fff && !wakeup_event_o)
    else $error("clocks not all on after reset");
  AST_LIGHT: assert property (wait_for_interrupt_entry_i && !deep_sleep_select_i && run_w
    |=> core_clk_en_o == 4'h7) else $error("light sleep enables wrong");
  AST_DEEP: assert property (wait_for_interrupt_entry_i && deep_sleep_select_i && run_w
    |=> core_clk_en_o == 4'h0) else $error("deep sleep enables wrong");
  AST_EVT: assert property (dma_done_i |=> wakeup_event_o) else $error("event missing");
  AST_EVT_CAUSE: assert property (wakeup_event_o |-> $past(dma_done_i))
    else $error("event without cause");
  AST_NMI_WAKE: assert property (core_clk_en_o == 4'h0 && !kind_ff && nmi_i
    |=> core_clk_en_o == 4'h7 ##1 run_w) else $error("nmi wake sequence wrong");
  AST_BUS_FIRST: assert property ($rose(core_clk_en_o.cpu)
    |-> $past(core_clk_en_o[2:0]) == 3'h7) else $error("cpu restarted before buses");
  AST_GATE_SRC: assert property ($changed(periph_clk_en_o) |-> $past(wr_w) || $past(wr_w, 2))
    else $error("gate changed without write");
  AST_ACK: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("no ack");
endmodule
bind lpcg_top lpcg_monitor i_mon (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_req_i, .wb_ack_o,
  .wb_dat_o, .wait_for_interrupt_entry_i, .wait_for_event_entry_i, .deep_sleep_select_i,
  .irq_i, .nmi_i, .dma_done_i, .wakeup_event_o, .core_clk_en_o, .periph_clk_en_o);

//--- dv/lpcg_core_model.sv
`timescale 1ns/1ps
module lpcg_core_model (
  input  wire logic  clk_i,
  output logic       wfi_o,
  output logic       wfe_o,
  output logic       deep_o,
  output logic [25:0] irq_o,
  output logic       nmi_o,
  output logic       dma_o
);
  initial {wfi_o, wfe_o, deep_o, irq_o, nmi_o, dma_o} = '0;
  // Deep select stays as a level, like the core's own bit
  task enter(input logic e, input logic d);
    @(posedge clk_i);
    wfi_o <= !e;
    wfe_o <= e;
    deep_o <= d;
    @(posedge clk_i);
    wfi_o <= 1'b0;
    wfe_o <= 1'b0;
  endtask
  // Completion held for n cycles; two in a row hit the cycle that consumes the first
  task dma(input int n);
    @(posedge clk_i);
    dma_o <= 1'b1;
    repeat (n) @(posedge clk_i);
    dma_o <= 1'b0;
  endtask
  task line(input logic [25:0] i, input logic n);
    @(posedge clk_i);
    irq_o <= i;
    nmi_o <= n;
  endtask
endmodule

//--- dv/tb.sv
`timescale 1ns/1ps
`include "lpcg_defs.svh"
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin miscompares++; \
  $display("mismatch t=%0t got=%h exp=%h", $time, a, b); end end
module tb;
  import lpcg_pkg::*;
  typedef struct {logic e; logic d; logic [3:0] x;} lpcg_row_s;
  logic             clk_i = 1'b0;
  logic             rst_i = 1'b1;
  logic             cyc = 1'b0;
  logic             stb = 1'b0;
  lpcg_wb_req_s     req = '0;
  logic             ack, wait_for_interrupt_entry, wait_for_event_entry, deep, nmi, dma, evt;
  logic [31:0]      rdat;
  logic [25:0]      irq;
  lpcg_core_clk_s   core;
  lpcg_periph_clk_s per;
  int               miscompares = 0;
  int               check_count = 0;
  lpcg_row_s        rows[4] = '{'{0, 0, 4'h7}, '{0, 1, 4'h0}, '{1, 0, 4'h7}, '{1, 1, 4'h0}};
  always #25 clk_i = ~clk_i;
  lpcg_core_model i_core (.clk_i(clk_i), .wfi_o(wait_for_interrupt_entry), .wfe_o(wait_for_event_entry), .deep_o(deep), .irq_o(irq),
    .nmi_o(nmi), .dma_o(dma));
  lpcg_top i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_req_i(req),
    .wb_ack_o(ack), .wb_dat_o(rdat), .wait_for_interrupt_entry_i(wait_for_interrupt_entry),
    .wait_for_event_entry_i(wait_for_event_entry), .deep_sleep_select_i(deep), .irq_i(irq), .nmi_i(nmi),
    .dma_done_i(dma), .wakeup_event_o(evt), .core_clk_en_o(core), .periph_clk_en_o(per));
  task wb(input logic [31:0] a, input logic w, input logic [31:0] d, input logic [3:0] s,
          output logic [31:0] q);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    req <= '{a, w, s, d};
    // Waits as long as the slave takes; only the watchdog ends a hung bus
    do begin
      @(posedge clk_i);
    end while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task final_report;
    $display("checks=%0d mismatches=%0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge clk_i);
    miscompares++;
    final_report;
  end
  initial begin
    logic [31:0] q;
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    @(negedge clk_i);
    `CHK(core, 4'hf)
    `CHK(per, 15'h7fff)
    foreach (rows[i]) begin
      i_core.enter(rows[i].e, rows[i].d);
      @(negedge clk_i);
      `CHK(core, rows[i].x)
      if (rows[i].e) i_core.dma(1);
      else i_core.line(26'h0, 1'b1);
      @(negedge clk_i);
      `CHK(evt, rows[i].e)
      @(negedge clk_i);
      `CHK(core, 4'h7)
      @(negedge clk_i);
      `CHK(core, 4'hf)
      i_core.line(26'h0, 1'b0);
    end
    wb(`LPCG_OFS_GATE, 1'b0, 32'h0000_0000, 4'hf, q);
    `CHK(q, 32'h0000_7fff)
    wb(`LPCG_OFS_GATE, 1'b1, 32'h0000_5a5a, 4'hf, q);
    @(negedge clk_i);
    `CHK(per, 15'h5a5a)
    // Only lane 1 selected: bits 14:8 change, bits 7:0 keep their value
    wb(`LPCG_OFS_GATE, 1'b1, 32'h0000_7fff, 4'h2, q);
    @(negedge clk_i);
    `CHK(per, 15'h7f5a)
    wb(32'h0000_000c, 1'b0, 32'h0000_0000, 4'hf, q);
    `CHK(q, 32'h0000_0000)
    wb(`LPCG_OFS_IRQMASK, 1'b1, 32'h0000_0001, 4'hf, q);
    // Masked line must not wake, unmasked one must
    i_core.enter(1'b0, 1'b0);
    i_core.line(26'h2, 1'b0);
    repeat (3) @(negedge clk_i);
    `CHK(core, 4'h7)
    wb(`LPCG_OFS_STATUS, 1'b0, 32'h0000_0000, 4'hf, q);
    `CHK(q, 32'h0000_0001)
    i_core.line(26'h1, 1'b0);
    repeat (3) @(negedge clk_i);
    `CHK(core, 4'hf)
    i_core.line(26'h0, 1'b0);
    i_core.dma(1);
    i_core.enter(1'b1, 1'b0);
    @(negedge clk_i);
    `CHK(core, 4'hf)
    // Asleep on an event wait: request lines and the non-maskable line must not wake
    i_core.enter(1'b1, 1'b1);
    i_core.line(26'h1, 1'b1);
    repeat (3) @(negedge clk_i);
    `CHK(core, 4'h0)
    wb(`LPCG_OFS_STATUS, 1'b0, 32'h0000_0000, 4'hf, q);
    `CHK(q, 32'h0000_002a)
    i_core.line(26'h0, 1'b0);
    i_core.dma(2);
    repeat (2) @(negedge clk_i);
    `CHK(core, 4'hf)
    wb(`LPCG_OFS_STATUS, 1'b0, 32'h0000_0000, 4'hf, q);
    `CHK(q, 32'h0000_0038)
    i_core.enter(1'b0, 1'b1);
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(negedge clk_i);
    `CHK({core, per}, 19'h7_ffff)
    wb(`LPCG_OFS_STATUS, 1'b0, 32'h0000_0000, 4'hf, q);
    `CHK(q, 32'h0000_0020)
    final_report;
  end
endmodule
